// File: hdl/tccu_pkg.sv
/*
 * Package for the timer capture/compare unit: register indices, control
 * bit positions, reset values and clock select encodings.
 * Assumes a byte-wide register port with one-cycle read latency.
 */
package tccu_pkg;
   // Register indices on the byte port
   localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
   localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_CAP1_HI = 4'h3;
   localparam logic [3:0] ADDR_CAP1_LO = 4'h4;
   localparam logic [3:0] ADDR_CMP1_HI = 4'h5;
   localparam logic [3:0] ADDR_CMP1_LO = 4'h6;
   localparam logic [3:0] ADDR_CAP2_HI = 4'h7;
   localparam logic [3:0] ADDR_CAP2_LO = 4'h8;
   localparam logic [3:0] ADDR_CMP2_HI = 4'h9;
   localparam logic [3:0] ADDR_CMP2_LO = 4'hA;
   localparam logic [3:0] ADDR_CNT_HI = 4'hB;
   localparam logic [3:0] ADDR_CNT_LO = 4'hC;
   // control_one bits
   localparam int C1_CAP_IRQ_EN = 7;
   localparam int C1_CMP_IRQ_EN = 6;
   localparam int C1_OVF_IRQ_EN = 5;
   localparam int C1_CAP1_EDGE = 1;
   localparam int C1_OUT1_LEVEL = 0;
   localparam int C1_OUT2_LEVEL = 2;
   // control_two bits
   localparam int C2_PIN1_EN = 7;
   localparam int C2_PIN2_EN = 6;
   localparam int C2_ONE_PULSE = 5;
   localparam int C2_PWM = 4;
   localparam int C2_CLK_HIGH = 3;
   localparam int C2_CLK_LOW = 2;
   localparam int C2_CAP2_EDGE = 1;
   localparam int C2_EXT_EDGE = 0;
   // timer_status bits
   localparam int ST_CAP1 = 7;
   localparam int ST_CMP1 = 6;
   localparam int ST_OVF = 5;
   localparam int ST_CAP2 = 4;
   localparam int ST_CMP2 = 3;
   // Clock select encodings
   localparam logic [1:0] CLK_DIV4 = 2'b00;
   localparam logic [1:0] CLK_DIV2 = 2'b01;
   localparam logic [1:0] CLK_DIV8 = 2'b10;
   localparam logic [1:0] CLK_EXT = 2'b11;
   // Reset values and counter maximum
   localparam logic [15:0] CMP_RESET = 16'h8000;
   localparam logic [15:0] CNT_RESET = 16'hFFFC;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [2:0] PRESC_ZERO = 3'h0;
endpackage : tccu_pkg

// File: hdl/tccu_capture.sv
/*
 * One input capture channel: edge detection, 16-bit latch, flag with the
 * two-step clear and the high/low read interlock.
 * Assumes the pin input is already synchronised to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module tccu_capture (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Synchronised pin and control
   input wire logic pin_sync_i,
   input wire logic edge_rise_i,
   input wire logic enable_i,
   input wire logic [15:0] count_i,
   // Software access events
   input wire logic status_seen_i,
   input wire logic read_high_i,
   input wire logic access_low_i,
   // Results
   output logic [15:0] value_o,
   output logic flag_o
);
   logic pin_prev_q;   // Previous pin level for edge detection
   logic locked_q;     // High byte read, low byte pending
   logic armed_q;      // Status was read while flag set
   logic hit;          // Active transition on pin

   // Edge detect on the already-synchronised level
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) pin_prev_q <= 1'b0;
      else pin_prev_q <= pin_sync_i;
   end

   // Pin direction plays no part; only the edge picked by edge_rise_i counts (see [R13])
   assign hit = enable_i && (edge_rise_i ? (pin_sync_i && !pin_prev_q)
                                         : (!pin_sync_i && pin_prev_q)); // see [R7]

   // Interlock opened by high read, closed by low access (see [R10])
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) locked_q <= 1'b0;
      else if (access_low_i) locked_q <= 1'b0;
      else if (read_high_i) locked_q <= 1'b1;
   end

   // Latest capture overwrites older value unless the interlock is set (see [R5]) (see [R11])
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) value_o <= 16'h0000;
      else if (hit && !locked_q) value_o <= count_i;
   end

   // Two-step clear; a new capture in the same cycle wins (see [R9])
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         flag_o <= 1'b0;
         armed_q <= 1'b0;
      end else if (hit && !locked_q) begin
         flag_o <= 1'b1; // see [R8]
         armed_q <= 1'b0;
      end else if (armed_q && access_low_i) begin
         flag_o <= 1'b0;
         armed_q <= 1'b0;
      end else if (status_seen_i && flag_o) begin
         armed_q <= 1'b1;
      end
   end
endmodule : tccu_capture
`default_nettype wire

// File: hdl/tccu_top.sv
/*
 * Capture/compare section of a 16-bit free-running timer: clock select,
 * counter, two capture channels, two compare channels and byte registers.
 * Assumes a byte register port, one clock at 10 MHz, pins unsynchronised.
 */
//
// Contract
// [R1] Both clock-select bits high select external clock
// [R2] Edge bit picks external clock active edge
// [R3] External edges synchronised to internal clock
// [R4] External clock slower than quarter CPU clock
// [R5] Capture latches counter on active edge
// [R6] Capture registers read-only, high and low bytes
// [R7] Per-channel edge polarity bit for capture
// [R8] Capture sets flag; gated interrupt request
// [R9] Capture flag cleared by status then low
// [R10] High-byte read blocks capture until low read
// [R11] Capture register holds most recent capture
// [R12] Pulse modes leave only second capture usable
// [R13] Capture works regardless of pin direction
// [R14] Compare each tick; match sets flag, interrupt
// [R15] Match drives pin level only when enabled
// [R16] Compare output latch low during reset
// [R17] Compare registers software-only, reset 8000h
// [R18] Compare flag cleared by status then low
// [R19] High-byte write suspends compare until low
// [R20] Software writes high, reads status, writes low
// [R21] Flag and pin change while count equals
// [R22] Free upcount; wrap sets overflow flag
// [R23] Internal clocks divide by 2, 4, 8
// [R24] Encodings 00 div4, 01 div2, 10 div8
`timescale 1ns/1ps
`default_nettype none
module tccu_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // CPU interrupt mask, high masks requests
   input wire logic cpu_irq_mask_i,
   output logic timer_irq_o,
   // Pins
   input wire logic ext_count_clock_pin_i,
   input wire logic capture_input_pin1_i,
   input wire logic capture_input_pin2_i,
   output logic compare_output_pin1_o,
   output logic compare_output_pin2_o,
   output logic compare_pin1_dedicated_o,
   output logic compare_pin2_dedicated_o
);
   import tccu_pkg::*;

   logic [7:0] control_one_q;   // Interrupt enables, edges, levels
   logic [7:0] control_two_q;   // Pin enables, modes, clock select
   logic [15:0] count_q;        // Free-running counter
   logic [15:0] cmp1_q;         // Compare value channel 1
   logic [15:0] cmp2_q;         // Compare value channel 2
   logic cmp1_hold_q;           // Compare 1 suspended after high write
   logic cmp2_hold_q;           // Compare 2 suspended after high write
   logic [2:0] presc_q;         // Internal prescaler
   logic [2:0] ext_sync_q;      // Two sync stages plus edge history
   logic [1:0] cap1_sync_q;     // Capture pin 1 synchroniser
   logic [1:0] cap2_sync_q;     // Capture pin 2 synchroniser
   logic tick_q;                // Counter advanced last cycle
   logic cmp1_flag_q, cmp2_flag_q, ovf_flag_q;
   logic cmp1_arm_q, cmp2_arm_q, ovf_arm_q;
   logic out1_q, out2_q;        // Compare output latches
   logic tick;                  // Counter advance this cycle
   logic ext_edge;              // Active external edge seen
   logic pulse_mode;            // One-pulse or PWM selected
   logic status_rd;             // Status register read
   logic [15:0] cap1_val, cap2_val;
   logic cap1_flag, cap2_flag;
   logic match1, match2;
   logic [7:0] rdata_d;
   logic [1:0] clk_sel;

   // True when a write or read hits the given index
   function automatic logic hit_reg(input logic [3:0] a, input logic [3:0] r,
                                    input logic s);
      hit_reg = s && (a == r);
   endfunction : hit_reg

   assign clk_sel = {control_two_q[C2_CLK_HIGH], control_two_q[C2_CLK_LOW]};
   assign pulse_mode = control_two_q[C2_ONE_PULSE] || control_two_q[C2_PWM];
   assign status_rd = hit_reg(addr_i, ADDR_STATUS, rd_i);

   // Pin synchronisers; the first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ext_sync_q <= 3'b000;
         cap1_sync_q <= 2'b00;
         cap2_sync_q <= 2'b00;
      end else begin
         ext_sync_q <= {ext_sync_q[1:0], ext_count_clock_pin_i}; // see [R3]
         cap1_sync_q <= {cap1_sync_q[0], capture_input_pin1_i};
         cap2_sync_q <= {cap2_sync_q[0], capture_input_pin2_i};
      end
   end

   // Edge on synchronised level; the source must leave four clocks
   // between active edges or some will be missed (see [R4])
   assign ext_edge = control_two_q[C2_EXT_EDGE]
                     ? (ext_sync_q[1] && !ext_sync_q[2])
                     : (!ext_sync_q[1] && ext_sync_q[2]); // see [R2]

   // Prescaler runs always so internal ticks stay evenly spaced
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) presc_q <= PRESC_ZERO;
      else presc_q <= presc_q + 3'd1;
   end

   // Tick select (see [R23]) (see [R24])
   always_comb begin
      case (clk_sel)
         CLK_DIV2: tick = (presc_q[0] == 1'b1);
         CLK_DIV4: tick = (presc_q[1:0] == 2'b11);
         CLK_DIV8: tick = (presc_q == 3'b111);
         CLK_EXT: tick = ext_edge; // see [R1]
         default: tick = 1'b0;
      endcase
   end

   // Free-running counter; a low-byte counter write reloads it
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) count_q <= CNT_RESET;
      else if (hit_reg(addr_i, ADDR_CNT_LO, wr_i)) count_q <= CNT_RESET;
      else if (tick) count_q <= count_q + 16'd1; // see [R22]
   end

   // Compare sees each new count value once, one cycle after the tick
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) tick_q <= 1'b0;
      else tick_q <= tick;
   end

   // Capture channel 1 is unusable in pulse modes (see [R12])
   tccu_capture u_cap1 (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_sync_i(cap1_sync_q[1]),
      .edge_rise_i(control_one_q[C1_CAP1_EDGE]),
      .enable_i(!pulse_mode),
      .count_i(count_q),
      .status_seen_i(status_rd),
      .read_high_i(hit_reg(addr_i, ADDR_CAP1_HI, rd_i)),
      .access_low_i(hit_reg(addr_i, ADDR_CAP1_LO, rd_i | wr_i)),
      .value_o(cap1_val),
      .flag_o(cap1_flag)
   );

   // Capture channel 2 stays usable in every mode
   tccu_capture u_cap2 (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_sync_i(cap2_sync_q[1]),
      .edge_rise_i(control_two_q[C2_CAP2_EDGE]),
      .enable_i(1'b1),
      .count_i(count_q),
      .status_seen_i(status_rd),
      .read_high_i(hit_reg(addr_i, ADDR_CAP2_HI, rd_i)),
      .access_low_i(hit_reg(addr_i, ADDR_CAP2_LO, rd_i | wr_i)),
      .value_o(cap2_val),
      .flag_o(cap2_flag)
   );

   // Control registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         control_one_q <= BYTE_ZERO;
         control_two_q <= BYTE_ZERO;
      end else begin
         if (hit_reg(addr_i, ADDR_CTRL_ONE, wr_i)) control_one_q <= wdata_i;
         if (hit_reg(addr_i, ADDR_CTRL_TWO, wr_i)) control_two_q <= wdata_i;
      end
   end

   // Compare values: software only, never touched by the timer (see [R17])
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cmp1_q <= CMP_RESET;
         cmp2_q <= CMP_RESET;
      end else begin
         if (hit_reg(addr_i, ADDR_CMP1_HI, wr_i)) cmp1_q[15:8] <= wdata_i;
         if (hit_reg(addr_i, ADDR_CMP1_LO, wr_i)) cmp1_q[7:0] <= wdata_i;
         if (hit_reg(addr_i, ADDR_CMP2_HI, wr_i)) cmp2_q[15:8] <= wdata_i;
         if (hit_reg(addr_i, ADDR_CMP2_LO, wr_i)) cmp2_q[7:0] <= wdata_i;
      end
   end

   // High write suspends matching until the low write (see [R19])
   // The high/status/low sequence avoids a stale flag (see [R20])
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cmp1_hold_q <= 1'b0;
         cmp2_hold_q <= 1'b0;
      end else begin
         if (hit_reg(addr_i, ADDR_CMP1_LO, wr_i)) cmp1_hold_q <= 1'b0;
         else if (hit_reg(addr_i, ADDR_CMP1_HI, wr_i)) cmp1_hold_q <= 1'b1;
         if (hit_reg(addr_i, ADDR_CMP2_LO, wr_i)) cmp2_hold_q <= 1'b0;
         else if (hit_reg(addr_i, ADDR_CMP2_HI, wr_i)) cmp2_hold_q <= 1'b1;
      end
   end

   // Match on the first cycle of each new count (see [R14]) (see [R21])
   assign match1 = tick_q && !cmp1_hold_q && (count_q == cmp1_q);
   assign match2 = tick_q && !cmp2_hold_q && (count_q == cmp2_q);

   // Compare flags; set wins over the second clear step (see [R18])
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cmp1_flag_q <= 1'b0;
         cmp1_arm_q <= 1'b0;
      end else if (match1) begin
         cmp1_flag_q <= 1'b1;
         cmp1_arm_q <= 1'b0;
      end else if (cmp1_arm_q && hit_reg(addr_i, ADDR_CMP1_LO, rd_i | wr_i)) begin
         cmp1_flag_q <= 1'b0;
         cmp1_arm_q <= 1'b0;
      end else if (status_rd && cmp1_flag_q) begin
         cmp1_arm_q <= 1'b1;
      end
   end

   // Compare flag 2, same scheme (see [R18])
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cmp2_flag_q <= 1'b0;
         cmp2_arm_q <= 1'b0;
      end else if (match2) begin
         cmp2_flag_q <= 1'b1;
         cmp2_arm_q <= 1'b0;
      end else if (cmp2_arm_q && hit_reg(addr_i, ADDR_CMP2_LO, rd_i | wr_i)) begin
         cmp2_flag_q <= 1'b0;
         cmp2_arm_q <= 1'b0;
      end else if (status_rd && cmp2_flag_q) begin
         cmp2_arm_q <= 1'b1;
      end
   end

   // Overflow flag, cleared by status read then counter low access
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ovf_flag_q <= 1'b0;
         ovf_arm_q <= 1'b0;
      end else if (tick && count_q == CNT_MAX) begin
         ovf_flag_q <= 1'b1; // see [R22]
         ovf_arm_q <= 1'b0;
      end else if (ovf_arm_q && hit_reg(addr_i, ADDR_CNT_LO, rd_i | wr_i)) begin
         ovf_flag_q <= 1'b0;
         ovf_arm_q <= 1'b0;
      end else if (status_rd && ovf_flag_q) begin
         ovf_arm_q <= 1'b1;
      end
   end

   // Output latches: low in reset, take level only if pin enabled
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         out1_q <= 1'b0; // see [R16]
         out2_q <= 1'b0; // see [R16]
      end else begin
         if (match1 && control_two_q[C2_PIN1_EN])
            out1_q <= control_one_q[C1_OUT1_LEVEL]; // see [R15]
         if (match2 && control_two_q[C2_PIN2_EN])
            out2_q <= control_one_q[C1_OUT2_LEVEL]; // see [R15]
      end
   end

   assign compare_output_pin1_o = out1_q;
   assign compare_output_pin2_o = out2_q;
   assign compare_pin1_dedicated_o = control_two_q[C2_PIN1_EN];
   assign compare_pin2_dedicated_o = control_two_q[C2_PIN2_EN];

   // Requests stay pending while masked (see [R8]) (see [R14])
   assign timer_irq_o = !cpu_irq_mask_i && (
      (control_one_q[C1_CAP_IRQ_EN] && (cap1_flag || cap2_flag)) ||
      (control_one_q[C1_CMP_IRQ_EN] && (cmp1_flag_q || cmp2_flag_q)) ||
      (control_one_q[C1_OVF_IRQ_EN] && ovf_flag_q));

   // Read mux; capture registers have no write path (see [R6])
   always_comb begin
      case (addr_i)
         ADDR_CTRL_ONE: rdata_d = control_one_q;
         ADDR_CTRL_TWO: rdata_d = control_two_q;
         ADDR_STATUS: rdata_d = {cap1_flag, cmp1_flag_q, ovf_flag_q,
                                 cap2_flag, cmp2_flag_q, 3'b000};
         ADDR_CAP1_HI: rdata_d = cap1_val[15:8];
         ADDR_CAP1_LO: rdata_d = cap1_val[7:0];
         ADDR_CMP1_HI: rdata_d = cmp1_q[15:8];
         ADDR_CMP1_LO: rdata_d = cmp1_q[7:0];
         ADDR_CAP2_HI: rdata_d = cap2_val[15:8];
         ADDR_CAP2_LO: rdata_d = cap2_val[7:0];
         ADDR_CMP2_HI: rdata_d = cmp2_q[15:8];
         ADDR_CMP2_LO: rdata_d = cmp2_q[7:0];
         ADDR_CNT_HI: rdata_d = count_q[15:8];
         ADDR_CNT_LO: rdata_d = count_q[7:0];
         default: rdata_d = BYTE_ZERO; // Unmapped reads zero
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) rdata_o <= BYTE_ZERO;
      else if (rd_i) rdata_o <= rdata_d;
      else rdata_o <= BYTE_ZERO;
   end
endmodule : tccu_top
`default_nettype wire

// File: sim/tccu_top_asserts.sv
/* Port-level assertions for tccu_top.
   Assumes it is bound to tccu_top and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module tccu_top_asserts (
   // Clock, reset and register port
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Interrupt
   input wire logic cpu_irq_mask_i,
   input wire logic timer_irq_o,
   // Pins
   input wire logic ext_count_clock_pin_i,
   input wire logic capture_input_pin1_i,
   input wire logic capture_input_pin2_i,
   input wire logic compare_output_pin1_o,
   input wire logic compare_output_pin2_o,
   input wire logic compare_pin1_dedicated_o,
   input wire logic compare_pin2_dedicated_o
);
   import tccu_pkg::*;
   logic lvl1_q; // Last written level bit, channel 1
   logic lvl2_q; // Last written level bit, channel 2
   // Shadow of the level bits, so pin moves can be tied to them
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         lvl1_q <= 1'b0;
         lvl2_q <= 1'b0;
      end else if (wr_i && addr_i == ADDR_CTRL_ONE) begin
         lvl1_q <= wdata_i[C1_OUT1_LEVEL];
         lvl2_q <= wdata_i[C1_OUT2_LEVEL];
      end
   end
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Write of control_two, then the one-cycle read-back of a compare byte
   sequence s_ctl2_wr;
      wr_i && addr_i == ADDR_CTRL_TWO;
   endsequence
   sequence s_cmp_wr_rd;
      wr_i && addr_i == ADDR_CMP1_HI ##1 rd_i && addr_i == ADDR_CMP1_HI;
   endsequence
   a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (rd_i && addr_i > ADDR_CNT_LO
      |=> rdata_o == 8'h00) else $error("unmapped read not zero");
   a_cmp_readback: assert property (
      s_cmp_wr_rd |=> rdata_o == $past(wdata_i, 2))
      else $error("compare byte read-back wrong");
   a_irq_masked: assert property (
      cpu_irq_mask_i |-> !timer_irq_o) else $error("request while masked");
   a_pin_reset: assert property (disable iff (1'b0)
      !rst_n_i |=> !compare_output_pin1_o && !compare_output_pin2_o)
      else $error("compare pin high in reset");
   a_pin1_level: assert property (
      $changed(compare_output_pin1_o) |-> $past(compare_pin1_dedicated_o)
      && compare_output_pin1_o == $past(lvl1_q))
      else $error("pin 1 moved wrongly");
   a_pin2_level: assert property (
      $changed(compare_output_pin2_o) |-> $past(compare_pin2_dedicated_o)
      && compare_output_pin2_o == $past(lvl2_q))
      else $error("pin 2 moved wrongly");
   a_ded_write: assert property (s_ctl2_wr |=>
      compare_pin1_dedicated_o == $past(wdata_i[C2_PIN1_EN])
      && compare_pin2_dedicated_o == $past(wdata_i[C2_PIN2_EN]))
      else $error("pin ownership not loaded");
   a_ded_hold: assert property (!(wr_i && addr_i == ADDR_CTRL_TWO) |=>
      $stable(compare_pin1_dedicated_o) && $stable(compare_pin2_dedicated_o))
      else $error("pin ownership moved without write");
endmodule : tccu_top_asserts
`default_nettype wire

// File: sim/tccu_pin_model.sv
/* Pin-side model: external count clock and the two capture inputs.
   Assumes its tasks are called right after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module tccu_pin_model (
   // Clock
   input wire logic clk_i,
   // Pins towards the timer
   output logic ext_count_clock_pin_o,
   output logic capture_input_pin1_o,
   output logic capture_input_pin2_o
);
   logic ext_q; // Count clock, stands low between bursts
   logic [1:0] cap_q; // Capture pin levels
   initial begin
      ext_q = 1'b0;
      cap_q = 2'b00;
   end
   assign ext_count_clock_pin_o = ext_q;
   assign capture_input_pin1_o = cap_q[0];
   assign capture_input_pin2_o = cap_q[1];
   // Pulses of eight cycles, well inside the quarter-rate limit
   task automatic ext(input int n);
      for (int i = 0; i < n; i++) begin
         ext_q <= 1'b1;
         repeat (4) @(posedge clk_i);
         ext_q <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
   endtask : ext
   // One transition on a capture pin
   task automatic toggle(input int ch);
      cap_q[ch] <= ~cap_q[ch];
      @(posedge clk_i);
   endtask : toggle
endmodule : tccu_pin_model
`default_nettype wire

// File: sim/tccu_top_test.sv
/* Self-checking bench for tccu_top with the pin model and checker.
   Assumes a 10 MHz clock; the counter is frozen on the external clock. */
`timescale 1ns/1ps
`default_nettype none
module tccu_top_test;
   import tccu_pkg::*;
   logic clk_i, rst_n_i, wr_i, rd_i, cpu_irq_mask_i, rd_v;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o;
   logic irq, ext_pin, cap1, cap2, pin1, pin2, ded1, ded2;
   logic [7:0] exp_q[$]; // Expected read data, oldest first
   logic [15:0] v;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   tccu_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .cpu_irq_mask_i(cpu_irq_mask_i), .timer_irq_o(irq),
      .ext_count_clock_pin_i(ext_pin), .capture_input_pin1_i(cap1),
      .capture_input_pin2_i(cap2), .compare_output_pin1_o(pin1),
      .compare_output_pin2_o(pin2), .compare_pin1_dedicated_o(ded1),
      .compare_pin2_dedicated_o(ded2));
   tccu_pin_model u_pins (.clk_i(clk_i), .ext_count_clock_pin_o(ext_pin),
      .capture_input_pin1_o(cap1), .capture_input_pin2_o(cap2));
   task automatic check(input string nm, input logic [7:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   // Bus tasks start just after an edge; strobes may run back to back
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      rd_i <= 1'b0;
      @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      addr_i <= a;
      rd_i <= 1'b1;
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask : rd
   task automatic idle(input int n);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      repeat (n) @(posedge clk_i);
   endtask : idle
   // Read data stands only in the cycle after the strobe
   always @(posedge clk_i) rd_v <= rd_i;
   always @(negedge clk_i) begin
      if (rd_v === 1'b1) check("rdata", rdata_o, exp_q.pop_front());
   end
   // Hang guard, far above the few hundred cycles needed
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      void'($urandom(32'hd2df4d7a));
      {rst_n_i, wr_i, rd_i, cpu_irq_mask_i, rd_v} = 5'h00;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(negedge clk_i);
      check("pins", {6'h00, pin1, pin2}, 8'h00);
      check("irq", {7'h00, irq}, 8'h00);
      @(posedge clk_i);
      wr(ADDR_CTRL_TWO, 8'h0F);
      wr(ADDR_CNT_LO, 8'h00);
      rd(ADDR_STATUS, 8'h00);
      rd(ADDR_CMP1_HI, 8'h80);
      rd(ADDR_CMP1_LO, 8'h00);
      rd(ADDR_CMP2_HI, 8'h80);
      rd(ADDR_CMP2_LO, 8'h00);
      for (int a = 13; a < 16; a++) rd(4'(a), 8'h00);
      // Random compare values kept clear of the counts used later
      for (int ch = 0; ch < 2; ch++) begin
         v = 16'($urandom_range(32'h7FFF, 32'h0100));
         wr(ch ? ADDR_CMP2_LO : ADDR_CMP1_LO, v[7:0]);
         wr(ch ? ADDR_CMP2_HI : ADDR_CMP1_HI, v[15:8]);
         rd(ch ? ADDR_CMP2_HI : ADDR_CMP1_HI, v[15:8]);
         rd(ch ? ADDR_CMP2_LO : ADDR_CMP1_LO, v[7:0]);
      end
      wr(ADDR_CTRL_TWO, 8'hCF);
      wr(ADDR_CTRL_ONE, 8'hC7);
      wr(ADDR_CMP1_HI, 8'h00);
      rd(ADDR_STATUS, 8'h00);
      wr(ADDR_CMP1_LO, 8'h03);
      wr(ADDR_CMP2_HI, 8'h00);
      wr(ADDR_CMP2_LO, 8'h05);
      idle(1);
      u_pins.toggle(0);
      idle(6);
      rd(ADDR_STATUS, 8'h80);
      idle(1);
      @(negedge clk_i);
      check("irq", {7'h00, irq}, 8'h01);
      @(posedge clk_i);
      cpu_irq_mask_i <= 1'b1;
      @(negedge clk_i);
      check("irq", {7'h00, irq}, 8'h00);
      @(posedge clk_i);
      cpu_irq_mask_i <= 1'b0;
      rd(ADDR_CAP1_HI, 8'hFF);
      wr(ADDR_CAP1_HI, 8'h00);
      rd(ADDR_CAP1_LO, 8'hFC);
      rd(ADDR_CAP1_HI, 8'hFF);
      rd(ADDR_CAP1_LO, 8'hFC);
      rd(ADDR_STATUS, 8'h00);
      idle(1);
      u_pins.toggle(1);
      idle(6);
      rd(ADDR_STATUS, 8'h10);
      rd(ADDR_CAP2_HI, 8'hFF);
      idle(1);
      u_pins.toggle(1);
      u_pins.ext(5);
      u_pins.toggle(1);
      idle(6);
      rd(ADDR_CAP2_LO, 8'hFC);
      rd(ADDR_STATUS, 8'h20);
      idle(1);
      u_pins.toggle(1);
      u_pins.toggle(1);
      idle(6);
      rd(ADDR_STATUS, 8'h30);
      rd(ADDR_CAP2_HI, 8'h00);
      rd(ADDR_CAP2_LO, 8'h01);
      idle(1);
      u_pins.ext(2);
      idle(4);
      @(negedge clk_i);
      check("pin1", {7'h00, pin1}, 8'h01);
      @(posedge clk_i);
      rd(ADDR_STATUS, 8'h60);
      wr(ADDR_CMP2_HI, 8'h00);
      idle(1);
      u_pins.ext(3);
      idle(4);
      rd(ADDR_STATUS, 8'h60);
      wr(ADDR_CMP2_LO, 8'h07);
      idle(1);
      u_pins.ext(1);
      idle(4);
      @(negedge clk_i);
      check("pin2", {7'h00, pin2}, 8'h01);
      @(posedge clk_i);
      rd(ADDR_STATUS, 8'h68);
      wr(ADDR_CMP1_LO, 8'h03);
      rd(ADDR_CMP2_LO, 8'h07);
      rd(ADDR_CNT_LO, 8'h07);
      rd(ADDR_STATUS, 8'h00);
      wr(ADDR_CTRL_TWO, 8'h0F);
      wr(ADDR_CTRL_ONE, 8'hC2);
      wr(ADDR_CMP1_HI, 8'h00);
      wr(ADDR_CMP1_LO, 8'h09);
      idle(1);
      u_pins.ext(2);
      idle(4);
      @(negedge clk_i);
      check("pin1", {6'h00, pin1, ded1}, 8'h02);
      @(posedge clk_i);
      rd(ADDR_STATUS, 8'h40);
      // Pulse modes: capture 1 ignored, capture 2 still works
      for (int m = 0; m < 2; m++) begin
         wr(ADDR_CTRL_TWO, m ? 8'h1F : 8'h2F);
         idle(1);
         u_pins.toggle(0);
         u_pins.toggle(0);
         idle(6);
         rd(ADDR_STATUS, 8'h40);
      end
      idle(1);
      u_pins.toggle(1);
      u_pins.toggle(1);
      idle(6);
      rd(ADDR_STATUS, 8'h50);
      rd(ADDR_CAP2_HI, 8'h00);
      rd(ADDR_CAP2_LO, 8'h09);
      idle(2);
      conclude();
   end
endmodule : tccu_top_test
// Checker ports share the names of the timer's own ports
bind tccu_top tccu_top_asserts u_chk (.*);
`default_nettype wire
